// ### rtl/aims_top.sv
// Analog input motion scaler: APB registers, learning, safe start, outputs
// Summary of operation
// - At power-up position mode learns current position from input, without moving.
// - After an error clears, position mode discards position and re-learns it.
// - Any analog mode drives the serial clock pin high to feed a potentiometer.
// - Position mode maps neutral to zero, input extremes to target limits.
// - Speed mode maps neutral to zero velocity, extremes to target velocity limits.
// - Scaling uses input max, neutral upper and lower, input min, invert flag.
// - Target maximum resets to 200, target minimum to -200.
// - With microstepping enabled, position limits are in microsteps, not full steps.
// - Speed mode holds motor de-energized, flags violation, until input seen neutral.
// - Disable-safe-start setting skips the neutral requirement before motion.
// - Invert-motor-direction setting reverses the physical step direction always.
// - Scaling degree resets to linear; higher degrees refine resolution near neutral.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
module aims_top (
  input  wire logic                       sys_clk,         // System clock, 25 MHz
  input  wire logic                       rst,             // Synchronous reset
  input  wire logic                       ce,              // Clock enable
  input  wire logic                       psel,            // APB select
  input  wire logic                       penable,         // APB enable
  input  wire logic                       pwrite,          // APB write
  input  wire logic [aims_pkg::ADDR_W-1:0] paddr,          // APB byte address
  input  wire logic [aims_pkg::DATA_W-1:0] pwdata,         // APB write data
  output logic [aims_pkg::DATA_W-1:0]     prdata,          // APB read data
  output logic                            pready,          // APB ready
  output logic                            pslverr,         // APB error
  input  wire logic [aims_pkg::ADC_W-1:0] ain_sample,      // Converted analog_input_pin
  input  wire logic                       ain_valid,       // Sample strobe
  input  wire logic                       fault_in,        // Error condition pin
  input  wire logic                       scl_i,           // Serial clock pin level
  output logic                            scl_o,           // Serial clock pin drive
  output logic                            scl_oe_n,        // Serial clock enable, low drives
  output logic [aims_pkg::DATA_W-1:0]     target_value,    // Target or learned position
  output logic                            target_stb,      // New target this cycle
  output logic                            set_pos_stb,     // Load current position
  output logic                            target_is_speed, // Target is a velocity
  output logic                            motor_energize,  // Motor may be energized
  output logic                            safe_start_viol, // Safe-start violation
  output logic                            motor_dir_inv,   // Reverse step direction
  output logic                            irq              // Interrupt, active high
);
  import aims_pkg::*;

  aims_ctrl_t       ctrl_r;
  logic [ADC_W-1:0] in_max_r;
  logic [ADC_W-1:0] neu_max_r;
  logic [ADC_W-1:0] neu_min_r;
  logic [ADC_W-1:0] in_min_r;
  logic [DATA_W-1:0] tgt_max_r;
  logic [DATA_W-1:0] tgt_min_r;
  logic [ST_W-1:0]  status_r;
  logic [ST_W-1:0]  mask_r;
  logic [ST_W-1:0]  ev_c;
  logic [ST_W-1:0]  w1c_c;
  logic [1:0]       pin_s1;
  logic [1:0]       pin_s2;
  logic [1:0]       pin_s3;
  logic [1:0]       pin_r;
  logic             fault_d_r;
  logic             fault_fall;
  logic [1:0]       mode_d_r;
  logic             mode_chg;
  logic             learn_pend_r;
  logic             armed_r;
  logic             safe_ok;
  logic [ADC_W-1:0] sample_r;
  logic             in_band;
  logic             sc_start;
  logic             sc_busy;
  logic             sc_done;
  logic             sc_fin;
  logic [DATA_W-1:0] sc_res;
  logic [DATA_W-1:0] scaled_c;
  logic             is_pos;
  logic             is_spd;
  logic             wr_en;
  logic             setup;
  aims_scale_cfg_t  scfg;

  // One decoder serves both the write enable and the error answer
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    if (a == OFS_CTRL) addr_ok = 1'b1;
    else if (a == OFS_IN_MAX) addr_ok = 1'b1;
    else if (a == OFS_NEU_MAX) addr_ok = 1'b1;
    else if (a == OFS_NEU_MIN) addr_ok = 1'b1;
    else if (a == OFS_IN_MIN) addr_ok = 1'b1;
    else if (a == OFS_TGT_MAX) addr_ok = 1'b1;
    else if (a == OFS_TGT_MIN) addr_ok = 1'b1;
    else if (a == OFS_STATUS) addr_ok = 1'b1;
    else if (a == OFS_MASK) addr_ok = 1'b1;
    else if (a == OFS_TARGET) addr_ok = 1'b1;
    else if (a == OFS_INPUT) addr_ok = 1'b1;
    else addr_ok = 1'b0;
  endfunction : addr_ok

  assign is_pos     = ctrl_r.mode == MODE_POS;
  assign is_spd     = ctrl_r.mode == MODE_SPD;
  assign setup      = psel && !penable;
  assign wr_en      = psel && penable && pwrite && addr_ok(paddr);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !addr_ok(paddr);
  assign w1c_c      = (wr_en && paddr == OFS_STATUS) ? pwdata[ST_W-1:0] : '0;

  // Pin synchronisers: a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_s1[i] <= 1'b0;
          pin_s2[i] <= 1'b0;
          pin_s3[i] <= 1'b0;
          pin_r[i]  <= 1'b0;
        end else if (ce) begin
          pin_s1[i] <= (i == 0) ? fault_in : scl_i;
          pin_s2[i] <= pin_s1[i];
          pin_s3[i] <= pin_s2[i];
          if (pin_s2[i] == pin_s3[i]) pin_r[i] <= pin_s3[i];
        end
      end
    end
  endgenerate

  assign fault_fall = fault_d_r && !pin_r[0];
  assign mode_chg   = ctrl_r.mode != mode_d_r;

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r    <= CTRL_RST;
      in_max_r  <= IN_MAX_RST;
      neu_max_r <= NEU_MAX_RST;
      neu_min_r <= NEU_MIN_RST;
      in_min_r  <= IN_MIN_RST;
      tgt_max_r <= TGT_MAX_RST;
      tgt_min_r <= TGT_MIN_RST;
      mask_r    <= '0;
    end else if (ce && wr_en) begin
      if (paddr == OFS_CTRL) ctrl_r <= aims_ctrl_t'(pwdata[CTRL_W-1:0]);
      else if (paddr == OFS_IN_MAX) in_max_r <= pwdata[ADC_W-1:0];
      else if (paddr == OFS_NEU_MAX) neu_max_r <= pwdata[ADC_W-1:0];
      else if (paddr == OFS_NEU_MIN) neu_min_r <= pwdata[ADC_W-1:0];
      else if (paddr == OFS_IN_MIN) in_min_r <= pwdata[ADC_W-1:0];
      else if (paddr == OFS_TGT_MAX) tgt_max_r <= pwdata;
      else if (paddr == OFS_TGT_MIN) tgt_min_r <= pwdata;
      else if (paddr == OFS_MASK) mask_r <= pwdata[ST_W-1:0];
    end
  end

  // Read data is latched in the setup phase so it is a flop during access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (ce && setup) begin
      if (paddr == OFS_CTRL) prdata <= DATA_W'(ctrl_r);
      else if (paddr == OFS_IN_MAX) prdata <= DATA_W'(in_max_r);
      else if (paddr == OFS_NEU_MAX) prdata <= DATA_W'(neu_max_r);
      else if (paddr == OFS_NEU_MIN) prdata <= DATA_W'(neu_min_r);
      else if (paddr == OFS_IN_MIN) prdata <= DATA_W'(in_min_r);
      else if (paddr == OFS_TGT_MAX) prdata <= tgt_max_r;
      else if (paddr == OFS_TGT_MIN) prdata <= tgt_min_r;
      else if (paddr == OFS_STATUS) prdata <= DATA_W'(status_r);
      else if (paddr == OFS_MASK) prdata <= DATA_W'(mask_r);
      else if (paddr == OFS_TARGET) prdata <= target_value;
      else if (paddr == OFS_INPUT) prdata <= {12'h000, armed_r, learn_pend_r,
                                               pin_r, 4'h0, sample_r};
      else prdata <= '0;
    end
  end

  // Scaler hand-off: a new sample is taken only when the scaler is idle
  assign sc_start = ain_valid && !sc_busy && (ctrl_r.mode != MODE_OFF);
  assign sc_fin   = sc_done && ce;
  assign in_band  = (sample_r >= neu_min_r) && (sample_r <= neu_max_r);

  always_ff @(posedge sys_clk) begin
    if (rst) sample_r <= '0;
    else if (ce && sc_start) sample_r <= ain_sample;
  end

  always_comb begin
    scfg.in_max    = in_max_r;
    scfg.neu_max   = neu_max_r;
    scfg.neu_min   = neu_min_r;
    scfg.in_min    = in_min_r;
    scfg.tgt_max   = tgt_max_r;
    scfg.tgt_min   = tgt_min_r;
    scfg.degree    = ctrl_r.degree;
    scfg.inv_input = ctrl_r.inv_input;
  end

  aims_scaler u_scaler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .start   (sc_start),
    .sample  (ain_sample),
    .cfg     (scfg),
    .busy    (sc_busy),
    .done    (sc_done),
    .result  (sc_res)
  );

  // Full-step limits become microsteps for a step generator that counts them
  assign scaled_c = (is_pos && !ctrl_r.microstep_en) ? (sc_res << ctrl_r.ustep_log2)
                                                     : sc_res;

  // Learning and safe-start state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_d_r    <= 1'b0;
      mode_d_r     <= MODE_OFF;
      learn_pend_r <= 1'b1;
      armed_r      <= 1'b0;
    end else if (ce) begin
      fault_d_r <= pin_r[0];
      mode_d_r  <= ctrl_r.mode;
      if (pin_r[0] || fault_fall || mode_chg) learn_pend_r <= 1'b1;
      else if (sc_done && is_pos) learn_pend_r <= 1'b0;
      if (pin_r[0] || mode_chg) armed_r <= 1'b0;
      else if (sc_done && in_band) armed_r <= 1'b1;
    end
  end

  // Arming left over from another mode must not energize the first speed cycle
  assign safe_ok = ctrl_r.dis_safe_start || (armed_r && !mode_chg);

  // Output stage: a learned position is loaded, never chased
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      target_value <= '0;
      target_stb   <= 1'b0;
      set_pos_stb  <= 1'b0;
    end else if (ce) begin
      target_stb  <= 1'b0;
      set_pos_stb <= 1'b0;
      if (sc_done && !pin_r[0]) begin
        if (is_pos && learn_pend_r) begin
          target_value <= scaled_c;
          set_pos_stb  <= 1'b1;
        end else if (!is_spd || safe_ok) begin
          target_value <= scaled_c;
          target_stb   <= 1'b1;
        end else begin
          target_value <= '0;
        end
      end
    end
  end

  assign target_is_speed = is_spd;
  assign motor_dir_inv   = ctrl_r.inv_motor;
  assign safe_start_viol = is_spd && !safe_ok;
  assign motor_energize  = (ctrl_r.mode != MODE_OFF) && !pin_r[0]
                           && !(is_spd && !safe_ok);
  // A potentiometer across the clock pin and ground needs a steady supply
  assign scl_o           = ctrl_r.mode != MODE_OFF;
  assign scl_oe_n        = ctrl_r.mode == MODE_OFF;

  // Sticky events; a set in the clear cycle wins
  always_comb begin
    ev_c            = '0;
    ev_c[ST_LEARN]  = set_pos_stb;
    ev_c[ST_TARGET] = target_stb;
    ev_c[ST_SAFE]   = sc_done && !pin_r[0] && is_spd && !safe_ok;
    ev_c[ST_ERRCLR] = fault_fall;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) status_r <= '0;
    else if (ce) status_r <= (status_r & ~w1c_c) | ev_c;
  end

  assign irq = |(status_r & mask_r);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_tgt_defaults: assert property ($fell(rst) |->
    tgt_max_r == TGT_MAX_RST && tgt_min_r == TGT_MIN_RST)
    else $error("target limits not at reset defaults");

  a_learn_reset: assert property ($fell(rst) |-> learn_pend_r)
    else $error("no learning pending after reset");

  a_learn_load: assert property (
    (sc_fin && is_pos && learn_pend_r && !pin_r[0])
    |=> set_pos_stb && !target_stb && target_value == $past(scaled_c))
    else $error("learned position not loaded without motion");

  a_fault_relearn: assert property ((ce && fault_fall) |=> learn_pend_r)
    else $error("no relearn after fault cleared");

  a_scl_drive: assert property ((ctrl_r.mode != MODE_OFF) |->
    scl_o && !scl_oe_n)
    else $error("clock pin not driven high in analog mode");

  a_neutral_zero: assert property ((sc_done && in_band) |-> sc_res == '0)
    else $error("neutral input did not scale to zero");

  a_sat_max: assert property (
    (sc_done && sample_r >= in_max_r && in_max_r > neu_max_r && !ctrl_r.inv_input
     && $stable(tgt_max_r) && $stable(ctrl_r))
    |-> sc_res == tgt_max_r)
    else $error("maximum input did not saturate at target maximum");

  a_ustep_scale: assert property (
    (sc_fin && is_pos && !ctrl_r.microstep_en && !pin_r[0])
    |=> target_value == ($past(sc_res) << $past(ctrl_r.ustep_log2)))
    else $error("full-step target not converted to microsteps");

  a_safe_gate: assert property (
    (is_spd && !ctrl_r.dis_safe_start && !armed_r)
    |-> safe_start_viol && !motor_energize ##1 (!target_stb || armed_r || mode_chg))
    else $error("motor energized before neutral seen");

  a_safe_skip: assert property ((is_spd && ctrl_r.dis_safe_start && !pin_r[0])
    |-> motor_energize && !safe_start_viol)
    else $error("disabled safe start still blocks motion");

  a_safe_entry: assert property (
    (is_spd && mode_chg && !ctrl_r.dis_safe_start) |-> !motor_energize && safe_start_viol)
    else $error("motor energized on entry to speed mode");

  a_speed_zero: assert property (
    (sc_fin && is_spd && in_band && safe_ok && !pin_r[0])
    |=> target_stb && target_value == '0)
    else $error("neutral input did not give zero velocity");

  a_fault_hold: assert property ((ce && pin_r[0]) |=> !target_stb && !set_pos_stb)
    else $error("result passed on during an error condition");

  a_scl_release: assert property ((ctrl_r.mode == MODE_OFF) |->
    scl_oe_n && !motor_energize)
    else $error("clock pin driven or motor energized while off");

  c_learn: cover property (set_pos_stb ##[1:100] target_stb);
  c_safe_release: cover property (safe_start_viol ##[1:200] !safe_start_viol && is_spd);
  c_fault_clear: cover property (fault_fall ##[1:300] set_pos_stb);
  c_irq: cover property ($rose(irq));
  c_speed_zero: cover property (target_stb && target_is_speed && target_value == '0);
endmodule : aims_top

// ### rtl/aims_pkg.sv
// Shared constants and types for the analog input motion scaler
package aims_pkg;
  localparam int ADC_W  = 12;
  localparam int DATA_W = 32;
  localparam int FRAC_W = 16;
  localparam int DEG_W  = 3;
  localparam int CNT_W  = 5;
  localparam int ST_W   = 4;
  localparam int CTRL_W = 12;
  localparam int ADDR_W = 8;

  // APB byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IN_MAX  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NEU_MAX = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_NEU_MIN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IN_MIN  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TGT_MAX = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TGT_MIN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TARGET  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_INPUT   = 8'h28;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_POS = 2'h1;
  localparam logic [1:0] MODE_SPD = 2'h2;

  // Status bit positions
  localparam int ST_LEARN  = 0;
  localparam int ST_TARGET = 1;
  localparam int ST_SAFE   = 2;
  localparam int ST_ERRCLR = 3;

  localparam logic [ADC_W-1:0]  IN_MAX_RST  = 12'hFFF;
  localparam logic [ADC_W-1:0]  NEU_MAX_RST = 12'h820;
  localparam logic [ADC_W-1:0]  NEU_MIN_RST = 12'h7E0;
  localparam logic [ADC_W-1:0]  IN_MIN_RST  = 12'h000;
  localparam logic [DATA_W-1:0] TGT_MAX_RST = 32'h000000C8;
  localparam logic [DATA_W-1:0] TGT_MIN_RST = 32'hFFFFFF38;
  localparam logic [DEG_W-1:0]  DEG_ONE     = 3'h1;
  localparam logic [FRAC_W:0]   FRAC_ONE    = 17'h10000;
  localparam logic [CNT_W-1:0]  DIV_STEPS   = 5'h10;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 5'h01;

  typedef struct packed {
    logic [DEG_W-1:0] degree;
    logic [2:0]       ustep_log2;
    logic             microstep_en;
    logic             dis_safe_start;
    logic             inv_motor;
    logic             inv_input;
    logic [1:0]       mode;
  } aims_ctrl_t;

  localparam aims_ctrl_t CTRL_RST = '{degree: DEG_ONE, default: '0};

  typedef struct packed {
    logic [ADC_W-1:0]  in_max;
    logic [ADC_W-1:0]  neu_max;
    logic [ADC_W-1:0]  neu_min;
    logic [ADC_W-1:0]  in_min;
    logic [DATA_W-1:0] tgt_max;
    logic [DATA_W-1:0] tgt_min;
    logic [DEG_W-1:0]  degree;
    logic              inv_input;
  } aims_scale_cfg_t;

  typedef enum logic [2:0] {
    SC_IDLE = 3'h0,
    SC_DIV  = 3'h1,
    SC_POW  = 3'h3,
    SC_MUL  = 3'h2,
    SC_DONE = 3'h6
  } aims_sc_state_t;
endpackage : aims_pkg

// ### rtl/aims_scaler.sv
// Sequential scaler from one analog sample to a signed target
`timescale 1ns/100ps
module aims_scaler (
  input  wire logic                     sys_clk,  // System clock
  input  wire logic                     rst,      // Synchronous reset
  input  wire logic                     ce,       // Clock enable
  input  wire logic                     start,    // Begin scaling sample
  input  wire logic [aims_pkg::ADC_W-1:0] sample, // Sample to scale
  input  wire aims_pkg::aims_scale_cfg_t cfg,     // Scaling settings
  output logic                          busy,     // Scaling in progress
  output logic                          done,     // Result valid this cycle
  output logic [aims_pkg::DATA_W-1:0]   result    // Signed scaled target
);
  import aims_pkg::*;

  aims_sc_state_t           state_r;
  logic                     pos_r;
  logic [ADC_W-1:0]         den_r;
  logic [ADC_W:0]           rem_r;
  logic [FRAC_W:0]          frac_r;
  logic [FRAC_W:0]          acc_r;
  logic [CNT_W-1:0]         cnt_r;
  logic [DEG_W-1:0]         pow_r;
  logic                     above;
  logic                     below;
  logic [ADC_W-1:0]         clip_hi;
  logic [ADC_W-1:0]         clip_lo;
  logic [ADC_W-1:0]         d_c;
  logic [ADC_W-1:0]         den_c;
  logic [ADC_W:0]           rem_sh;
  logic [2*FRAC_W+1:0]      p_pow;
  logic [DATA_W-1:0]        mag_c;
  logic [FRAC_W+DATA_W:0]   p_mul;
  logic [DATA_W-1:0]        m_c;

  always_comb begin
    above   = sample > cfg.neu_max;
    below   = sample < cfg.neu_min;
    clip_hi = (sample > cfg.in_max) ? cfg.in_max : sample;
    clip_lo = (sample < cfg.in_min) ? cfg.in_min : sample;
    if (above) begin
      d_c   = clip_hi - cfg.neu_max;
      den_c = cfg.in_max - cfg.neu_max;
    end else begin
      d_c   = cfg.neu_min - clip_lo;
      den_c = cfg.neu_min - cfg.in_min;
    end
  end

  assign rem_sh = {rem_r[ADC_W-1:0], 1'b0};
  assign p_pow  = acc_r * frac_r;
  // Negating the lower limit as unsigned keeps the most negative value exact
  assign mag_c  = pos_r ? cfg.tgt_max : (DATA_W'(0) - cfg.tgt_min);
  assign p_mul  = acc_r * mag_c;
  assign m_c    = p_mul[FRAC_W+DATA_W-1:FRAC_W];
  assign busy   = state_r != SC_IDLE;
  assign done   = state_r == SC_DONE;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= SC_IDLE;
      pos_r   <= 1'b0;
      den_r   <= '0;
      rem_r   <= '0;
      frac_r  <= '0;
      acc_r   <= '0;
      cnt_r   <= '0;
      pow_r   <= '0;
      result  <= '0;
    end else if (ce) begin
      case (state_r)
        SC_IDLE: if (start) begin
          pos_r  <= above ^ cfg.inv_input;
          acc_r  <= FRAC_ONE;
          pow_r  <= (cfg.degree == '0) ? DEG_ONE : cfg.degree;
          den_r  <= den_c;
          rem_r  <= {1'b0, d_c};
          frac_r <= '0;
          cnt_r  <= DIV_STEPS;
          if (!above && !below) begin
            result  <= '0;
            state_r <= SC_DONE;
          end else if (d_c >= den_c) begin
            frac_r  <= FRAC_ONE;
            state_r <= SC_POW;
          end else begin
            state_r <= SC_DIV;
          end
        end
        SC_DIV: begin
          if (rem_sh >= {1'b0, den_r}) begin
            rem_r  <= rem_sh - {1'b0, den_r};
            frac_r <= {frac_r[FRAC_W-1:0], 1'b1};
          end else begin
            rem_r  <= rem_sh;
            frac_r <= {frac_r[FRAC_W-1:0], 1'b0};
          end
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_ONE) state_r <= SC_POW;
        end
        SC_POW: begin
          // Raising the fraction to the degree flattens the curve near neutral
          if (pow_r == '0) begin
            state_r <= SC_MUL;
          end else begin
            acc_r <= p_pow[2*FRAC_W:FRAC_W];
            pow_r <= pow_r - 1'b1;
          end
        end
        SC_MUL: begin
          result  <= pos_r ? m_c : (DATA_W'(0) - m_c);
          state_r <= SC_DONE;
        end
        default: state_r <= SC_IDLE;
      endcase
    end
  end
endmodule : aims_scaler

// ### bench/aims_pot_model.sv
// Potentiometer source model feeding the converted analog input
`timescale 1ns/100ps
module aims_pot_model (
  input  wire logic                       sys_clk,    // System clock
  input  wire logic                       supply,     // Pot top end fed by serial clock pin
  input  wire logic [aims_pkg::ADC_W-1:0] level,      // Wiper position
  input  wire logic                       req,        // Conversion request
  input  wire logic [3:0]                 lag,        // Conversion delay in cycles
  output logic [aims_pkg::ADC_W-1:0]      ain_sample, // Converted wiper voltage
  output logic                            ain_valid   // Sample strobe
);
  logic [3:0] cnt = 4'h0;
  logic       pend = 1'b0;
  initial begin
    ain_sample = 12'h000;
    ain_valid = 1'b0;
  end
  always @(posedge sys_clk) begin
    ain_valid <= 1'b0;
    ain_sample <= ~ain_sample; // Never hold a stale sample between strobes
    if (req) begin
      pend <= 1'b1;
      cnt <= lag;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend <= 1'b0;
      ain_valid <= 1'b1;
      ain_sample <= supply ? level : 12'h000; // Unfed pot reads ground
    end
  end
endmodule : aims_pot_model

// ### bench/aims_top_tb.sv
// Self-checking bench for the analog input motion scaler
`timescale 1ns/100ps
module aims_top_tb;
  import aims_pkg::*;
  logic sys_clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, fault_in = 0, req = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, target_value, q;
  logic pready, pslverr, scl_o, scl_oe_n, scl_i, target_stb, set_pos_stb, target_is_speed;
  logic motor_energize, safe_start_viol, motor_dir_inv, irq, ain_valid, e;
  logic [11:0] ain_sample, level = 0;
  logic [3:0] lag = 0;
  logic [32:0] expq[$];
  int checks = 0, miscompares = 0, t, d;
  longint fr, ac;
  assign scl_i = scl_oe_n ? 1'b1 : scl_o; // Pulled up when released
  aims_top dut (.sys_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ain_sample, .ain_valid, .fault_in, .scl_i, .scl_o, .scl_oe_n,
    .target_value, .target_stb, .set_pos_stb, .target_is_speed, .motor_energize,
    .safe_start_viol, .motor_dir_inv, .irq);
  aims_pot_model pot (.sys_clk, .supply(scl_i), .level, .req, .lag, .ain_sample, .ain_valid);
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    checks++;
    if (seen !== ex) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    int n;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      miscompares++;
      report_and_stop();
    end
    @(posedge sys_clk);
  endtask : apb
  task automatic feed(input logic [11:0] lv, input logic want, input logic [32:0] ex);
    level <= lv;
    lag <= 4'($urandom_range(0, 15));
    req <= 1;
    if (want) expq.push_back(ex);
    @(posedge sys_clk);
    req <= 0;
    repeat (70) @(posedge sys_clk);
    chk("pending results", 33'(expq.size()), 33'h0);
  endtask : feed
  always @(posedge sys_clk) begin
    if (target_stb === 1'b1 || set_pos_stb === 1'b1)
      chk("result", {set_pos_stb, target_value}, expq.size() ? expq.pop_front() : 'x);
  end
  initial begin
    void'($urandom(69));
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    apb(0, OFS_TGT_MAX, 0);
    chk("tgt max", 33'(q), 33'hC8);
    apb(0, OFS_TGT_MIN, 0);
    chk("tgt min", 33'(q), 33'hFFFFFF38);
    apb(0, OFS_CTRL, 0);
    chk("ctrl", 33'(q), 33'h200);
    apb(1, 8'h40, 1);
    chk("unmapped", 33'(e), 33'h1);
    apb(1, OFS_MASK, 2);
    apb(1, OFS_CTRL, 32'h201);
    chk("scl", 33'({scl_o, scl_oe_n}), 33'h2);
    feed(12'hFFF, 1, {1'b1, 32'hC8});
    feed(12'h800, 1, 33'h0);
    feed(12'h000, 1, 33'hFFFFFF38);
    chk("irq set", 33'(irq), 33'h1);
    apb(1, OFS_STATUS, 2);
    chk("irq clear", 33'(irq), 33'h0);
    fault_in <= 1;
    repeat (10) @(posedge sys_clk);
    fault_in <= 0;
    repeat (10) @(posedge sys_clk);
    feed(12'hFFF, 1, {1'b1, 32'hC8});
    apb(1, OFS_CTRL, 32'h281);
    feed(12'hFFF, 1, 33'h320);
    apb(1, OFS_CTRL, 32'h2A1);
    feed(12'hFFF, 1, 33'hC8);
    apb(1, OFS_CTRL, 32'h205);
    feed(12'hFFF, 1, 33'hFFFFFF38);
    apb(1, OFS_CTRL, 32'h20A);
    feed(12'hFFF, 0, 0);
    chk("unarmed", 33'({safe_start_viol, motor_energize}), 33'h2);
    chk("dir", 33'({target_is_speed, motor_dir_inv}), 33'h3);
    // The arming sample itself is still held back, as the motor is not yet released
    feed(12'h800, 0, 0);
    chk("held zero", 33'(target_value), 33'h0);
    chk("armed", 33'({safe_start_viol, motor_energize}), 33'h1);
    feed(12'hFFF, 1, 33'hC8);
    apb(1, OFS_CTRL, 32'h212);
    feed(12'hFFF, 1, 33'hC8);
    for (int i = 0; i < 4; i++) begin
      t = $urandom_range(1, 1000);
      d = $urandom_range(1, 7);
      apb(1, OFS_TGT_MAX, t); // Limit kept at or above zero
      apb(1, OFS_CTRL, 32'h12 | (d << 9));
      feed(12'hFFF, 1, 33'(t));
      // Mid-range input: fraction of span, raised to the degree, times the limit
      fr = (longint'(12'hC10 - NEU_MAX_RST) << 16) / longint'(IN_MAX_RST - NEU_MAX_RST);
      ac = 64'h10000;
      repeat (d) ac = (ac * fr) >> 16;
      feed(12'hC10, 1, 33'((ac * t) >> 16));
      feed(12'h800, 1, 33'h0);
    end
    report_and_stop();
  end
endmodule : aims_top_tb
